// ==== src/period_timer_pkg.sv ====
// Package of constants for the 8-bit period-match timer.
// Assumes an APB slave with 8-bit addresses and 32-bit data on pclk.
package period_timer_pkg;

	// ======================================================
	// Register byte offsets
	localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] OFF_PERIOD_VALUE = 8'h04;
	localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
	localparam logic [7:0] OFF_PERIPH_FLAG = 8'h0C;
	localparam logic [7:0] OFF_PERIPH_ENABLE = 8'h10;

	// ======================================================
	// Field positions of timer_control
	localparam int CTRL_PRE_LSB = 0;
	localparam int CTRL_RUN_BIT = 2;
	localparam int CTRL_POST_LSB = 3;
	localparam int CTRL_POST_MSB = 6;
	// Field position of match flag and its enable
	localparam int MATCH_BIT = 1;

	// ======================================================
	// Values after reset
	localparam logic [6:0] RST_TIMER_CONTROL = 7'h00;
	localparam logic [7:0] RST_PERIOD_VALUE = 8'hFF;
	localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
	localparam logic [3:0] RST_SCALER = 4'h0;

	// ======================================================
	// Cycle counts
	// Instruction clock is pclk divided by four
	localparam logic [1:0] INST_PHASE_LAST = 2'h3;
	// Last prescaler state for divide by 1, 4 and 16
	localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
	localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
	localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
	// Prescale select codes
	localparam logic [1:0] PRE_SEL_DIV1 = 2'h0;
	localparam logic [1:0] PRE_SEL_DIV4 = 2'h1;

endpackage

// ==== src/period_match_timer.sv ====
// 8-bit period-match timer with prescaler, postscaler, match flag and APB registers.
// Assumes one clock pclk (the oscillator), APB master on the same clock, low reset.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps

module period_match_timer
	import period_timer_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic match_pulse,
	output logic timer_shift_clk
);

	// ======================================================
	// State
	logic [6:0] timer_control;
	logic [7:0] period_value;
	logic [7:0] timer_count;
	logic match_flag;
	logic match_irq_enable;
	logic [1:0] inst_phase;
	logic [3:0] pre_cnt;
	logic [3:0] post_cnt;

	// ======================================================
	// APB decode
	wire logic access_wr = psel && penable && pwrite;
	wire logic hit_ctrl = (paddr == OFF_TIMER_CONTROL);
	wire logic hit_period = (paddr == OFF_PERIOD_VALUE);
	wire logic hit_count = (paddr == OFF_TIMER_COUNT);
	wire logic hit_flag = (paddr == OFF_PERIPH_FLAG);
	wire logic hit_enable = (paddr == OFF_PERIPH_ENABLE);
	wire logic hit_any = hit_ctrl || hit_period || hit_count || hit_flag || hit_enable;
	wire logic ctrl_wr = access_wr && hit_ctrl;
	wire logic period_wr = access_wr && hit_period;
	wire logic cnt_wr = access_wr && hit_count;
	wire logic flag_wr = access_wr && hit_flag;
	wire logic enable_wr = access_wr && hit_enable;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	// ======================================================
	// Control fields
	wire logic [1:0] prescale_select = timer_control[CTRL_PRE_LSB +: 2];
	wire logic timer_run = timer_control[CTRL_RUN_BIT];
	wire logic [3:0] postscale_select = timer_control[CTRL_POST_MSB:CTRL_POST_LSB];

	// Prescaler terminal state per select code
	wire logic [3:0] pre_last = (prescale_select == PRE_SEL_DIV1) ? PRE_LAST_DIV1 :
		(prescale_select == PRE_SEL_DIV4) ? PRE_LAST_DIV4 : PRE_LAST_DIV16;

	// ======================================================
	// Tick and match generation
	wire logic inst_tick = (inst_phase == INST_PHASE_LAST);
	wire logic tick = timer_run && inst_tick && (pre_cnt == pre_last);
	wire logic count_eq = (timer_count == period_value);
	wire logic match_now = tick && count_eq;
	wire logic post_expire = match_now && (post_cnt == postscale_select);
	wire logic scaler_clear = ctrl_wr || cnt_wr;

	// Instruction-clock phase, free running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inst_phase <= 2'h0;
		end else begin
			inst_phase <= inst_phase + 2'h1;
		end
	end

	// Prescaler: held while off, cleared by control and count writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt <= RST_SCALER;
		end else if (scaler_clear) begin
			pre_cnt <= RST_SCALER;
		end else if (tick) begin
			pre_cnt <= RST_SCALER;
		end else if (timer_run && inst_tick) begin
			pre_cnt <= pre_cnt + 4'h1;
		end
	end

	// Count register: software write wins over the tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count <= RST_TIMER_COUNT;
		end else if (cnt_wr) begin
			timer_count <= pwdata[7:0];
		end else if (match_now) begin
			timer_count <= RST_TIMER_COUNT;
		end else if (tick) begin
			timer_count <= timer_count + 8'h01;
		end
	end

	// Postscaler counts matches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_cnt <= RST_SCALER;
		end else if (scaler_clear) begin
			post_cnt <= RST_SCALER;
		end else if (post_expire) begin
			post_cnt <= RST_SCALER;
		end else if (match_now) begin
			post_cnt <= post_cnt + 4'h1;
		end
	end

	// Unscaled match pulse and toggling shift clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_pulse <= 1'b0;
			timer_shift_clk <= 1'b0;
		end else begin
			match_pulse <= match_now;
			timer_shift_clk <= timer_shift_clk ^ match_now;
		end
	end

	// ======================================================
	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control <= RST_TIMER_CONTROL;
			period_value <= RST_PERIOD_VALUE;
			match_irq_enable <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				timer_control <= pwdata[6:0];
			end
			if (period_wr) begin
				period_value <= pwdata[7:0];
			end
			if (enable_wr) begin
				match_irq_enable <= pwdata[MATCH_BIT];
			end
		end
	end

	// Match flag: set by postscaler, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_flag <= 1'b0;
		end else if (post_expire) begin
			match_flag <= 1'b1;
		end else if (flag_wr && pwdata[MATCH_BIT]) begin
			match_flag <= 1'b0;
		end
	end

	// Interrupt level gated by enable
	assign irq = match_flag && match_irq_enable;

	// ======================================================
	// Read data, captured in the setup cycle
	wire logic [31:0] next_prdata = hit_ctrl ? {25'h0, timer_control} :
		hit_period ? {24'h0, period_value} :
		hit_count ? {24'h0, timer_count} :
		hit_flag ? {30'h0, match_flag, 1'b0} :
		hit_enable ? {30'h0, match_irq_enable, 1'b0} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= next_prdata;
		end
	end

	// ======================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_div1_tick;
		tick && (prescale_select == PRE_SEL_DIV1) && !scaler_clear;
	endsequence

	sequence s_quiet4;
		(timer_run && !ctrl_wr && !cnt_wr)[*4];
	endsequence

	sequence s_last_match;
		match_now && (post_cnt == postscale_select) && !scaler_clear;
	endsequence

	a_count_step: assert property (
		(tick && !count_eq && !cnt_wr) |=> (timer_count == $past(timer_count) + 8'h01)
	) else $error("count did not step on tick");

	a_tick_spacing: assert property (
		tick |=> !tick [*3]
	) else $error("ticks closer than one instruction cycle");

	a_div1_period: assert property (
		s_div1_tick ##1 s_quiet4 |-> tick
	) else $error("divide by one tick missing");

	a_match_cause: assert property (
		match_pulse |-> $past(count_eq && tick)
	) else $error("match pulse without equal count");

	a_match_clear: assert property (
		(match_now && !cnt_wr) |=> (timer_count == 8'h00) && match_pulse
	) else $error("count not cleared after match");

	a_scaler_clear: assert property (
		scaler_clear |=> (pre_cnt == 4'h0) && (post_cnt == 4'h0)
	) else $error("scalers not cleared by write");

	a_ctrl_keep: assert property (
		(ctrl_wr && !tick && !cnt_wr) |=> $stable(timer_count)
	) else $error("control write changed count");

	a_post_flag: assert property (
		s_last_match |=> match_flag ##1 (post_cnt == 4'h0 || scaler_clear)
	) else $error("postscaler did not set flag");

	a_flag_cause: assert property (
		$rose(match_flag) |-> $past(post_expire)
	) else $error("flag set without postscaler expiry");

	a_irq_gate: assert property (
		(post_expire && match_irq_enable && !enable_wr) |=> irq
	) else $error("expiry with enable set gave no interrupt");

	a_off_hold: assert property (
		(!timer_run && !cnt_wr) |=> $stable(timer_count) && !match_pulse
	) else $error("timer moved while off");

	a_bit7_zero: assert property (
		(psel && !penable && hit_ctrl) |=> prdata[7] == 1'b0
	) else $error("control bit 7 read as one");

	// ======================================================
	// Check helpers: cycles since the last tick
	// Cleared by any scaler clear that is not itself a tick,
	// so only gaps between two undisturbed ticks are judged
	logic [6:0] tick_gap;
	logic tick_clean;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_gap <= 7'h00;
			tick_clean <= 1'b0;
		end else begin
			if (tick) begin
				tick_gap <= 7'h00;
			end else if (tick_gap != 7'h7F) begin
				tick_gap <= tick_gap + 7'h01; // Saturates
			end
			if (tick) begin
				tick_clean <= 1'b1;
			end else if (scaler_clear) begin
				tick_clean <= 1'b0;
			end
		end
	end

	// ======================================================
	// Checks of the division ratios
	a_gap_div1: assert property (
		(tick && tick_clean && prescale_select == PRE_SEL_DIV1) |->
			(tick_gap == {1'b0, PRE_LAST_DIV1, INST_PHASE_LAST})
	) else $error("divide by one ticks at wrong spacing");

	a_gap_div4: assert property (
		(tick && tick_clean && prescale_select == PRE_SEL_DIV4) |->
			(tick_gap == {1'b0, PRE_LAST_DIV4, INST_PHASE_LAST})
	) else $error("divide by four ticks at wrong spacing");

	a_gap_div16: assert property (
		(tick && tick_clean && prescale_select[1]) |->
			(tick_gap == {1'b0, PRE_LAST_DIV16, INST_PHASE_LAST})
	) else $error("divide by sixteen ticks at wrong spacing");

	a_pre_bound: assert property (
		pre_cnt <= pre_last
	) else $error("prescaler ran past its terminal state");

	// ======================================================
	// Checks of the postscaler and the off state
	a_post_bound: assert property (
		post_cnt <= postscale_select
	) else $error("postscaler ran past its select value");

	a_post_step: assert property (
		(match_now && !post_expire && !scaler_clear) |=> (post_cnt == $past(post_cnt) + 4'h1)
	) else $error("postscaler did not count a match");

	a_pre_hold: assert property (
		(!timer_run && !scaler_clear) |=> $stable(pre_cnt) && $stable(post_cnt)
	) else $error("scalers moved while off");

	a_count_hold: assert property (
		(!tick && !cnt_wr) |=> $stable(timer_count)
	) else $error("count moved without a tick");

	// ======================================================
	// Checks of the flag and the interrupt
	a_flag_set: assert property (
		post_expire |=> match_flag
	) else $error("postscaler expiry did not set flag");

	a_flag_hold: assert property (
		(match_flag && !(flag_wr && pwdata[MATCH_BIT])) |=> match_flag
	) else $error("flag dropped without a clear");

	a_flag_clear: assert property (
		(flag_wr && pwdata[MATCH_BIT] && !post_expire) |=> !match_flag
	) else $error("flag not cleared by writing one");

	a_irq_hold: assert property (
		(irq && !flag_wr && !enable_wr) |=> irq
	) else $error("interrupt dropped while flag and enable kept");

	a_irq_masked: assert property (
		(!match_irq_enable && !enable_wr) |=> !irq
	) else $error("interrupt while enable clear");

	// ======================================================
	// Checks of the software registers and the outputs
	a_count_write: assert property (
		cnt_wr |=> (timer_count == $past(pwdata[7:0]))
	) else $error("count write not stored");

	a_period_write: assert property (
		period_wr |=> (period_value == $past(pwdata[7:0]))
	) else $error("period write not stored");

	a_period_keep: assert property (
		!period_wr |=> $stable(period_value)
	) else $error("period changed without a write");

	a_ctrl_write: assert property (
		ctrl_wr |=> (timer_control == $past(pwdata[6:0]))
	) else $error("control write not stored");

	a_read_hold: assert property (
		!(psel && !penable) |=> $stable(prdata)
	) else $error("read data changed outside a setup cycle");

	a_pulse_single: assert property (
		match_pulse |=> !match_pulse
	) else $error("match pulse longer than one cycle");

	a_shift_toggle: assert property (
		match_now |=> (timer_shift_clk != $past(timer_shift_clk))
	) else $error("shift clock did not toggle on match");

	a_shift_hold: assert property (
		!match_now |=> $stable(timer_shift_clk)
	) else $error("shift clock moved without a match");

endmodule

// ==== testbench/testbench.sv ====
// Self-checking testbench for the 8-bit period-match timer.
// Assumes the timer package and a zero-wait APB slave on pclk.
`timescale 1ns/100ps

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module testbench import period_timer_pkg::*;;
	// ==========================================================
	// Stimulus, observed outputs and counters
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, match_pulse, timer_shift_clk, err, s, seen;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int n, k;
	logic [7:0] offs [5] = '{OFF_TIMER_CONTROL, OFF_PERIOD_VALUE, OFF_TIMER_COUNT,
		OFF_PERIPH_FLAG, OFF_PERIPH_ENABLE};
	logic [31:0] rstv [5] = '{32'h00, 32'hFF, 32'h00, 32'h00, 32'h00};
	logic [3:0] posts [3] = '{4'h0, 4'h3, 4'hF};
	int divs [4] = '{1, 4, 16, 16};

	period_match_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.match_pulse(match_pulse), .timer_shift_clk(timer_shift_clk));

	// 10 MHz clock and a ceiling on run length
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end

	// ==========================================================
	// APB transfer: setup, then access until pready, entered just after an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk); // Idle cycle, so no strobe is assigned twice in one step
	endtask

	// Stop, clear flag and count, then start with the given control value
	task automatic arm(input logic [7:0] c);
		xfer(1'b1, OFF_TIMER_CONTROL, {24'h000000, c & 8'hFB});
		xfer(1'b1, OFF_PERIPH_FLAG, 32'h00000002);
		xfer(1'b1, OFF_TIMER_COUNT, 32'h00000000);
		xfer(1'b1, OFF_TIMER_CONTROL, {24'h000000, c});
	endtask

	// Cycles until the next match pulse is seen, bounded
	task automatic wait_match();
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (match_pulse !== 1'b1 && n < 1000);
	endtask

	task automatic summarize();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Values after reset
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, offs[i], 32'h0);
			`CHK(rd, rstv[i])
		end
		xfer(1'b0, 8'h14, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h00000000)
		// Match interval per prescale code, period of three ticks
		xfer(1'b1, OFF_PERIOD_VALUE, 32'h00000002);
		xfer(1'b1, OFF_PERIPH_ENABLE, 32'h00000002);
		for (int i = 0; i < 4; i++) begin
			arm(8'h04 | 8'(i));
			wait_match();
			s = timer_shift_clk;
			wait_match();
			`CHK(n, 12 * divs[i])
			`CHK(timer_shift_clk, ~s)
			@(posedge pclk);
			`CHK(match_pulse, 1'b0)
		end
		// Flag after post+1 matches
		for (int i = 0; i < 3; i++) begin
			arm({1'b0, posts[i], 3'b100});
			k = 0;
			do begin
				wait_match();
				k++;
			end while (irq !== 1'b1 && k < 20);
			`CHK(k, int'(posts[i]) + 1)
		end
		// Control write mid-way restarts the postscaler, set for four matches
		arm(8'h1C);
		wait_match();
		wait_match();
		xfer(1'b1, OFF_TIMER_CONTROL, 32'h0000001C);
		k = 0;
		do begin
			wait_match();
			k++;
		end while (irq !== 1'b1 && k < 20);
		`CHK(k, 4)
		// Masking and clearing the flag
		xfer(1'b1, OFF_TIMER_CONTROL, 32'h00000000);
		xfer(1'b1, OFF_PERIPH_ENABLE, 32'h00000000);
		xfer(1'b0, OFF_PERIPH_FLAG, 32'h0);
		`CHK(rd, 32'h00000002)
		`CHK(irq, 1'b0)
		xfer(1'b1, OFF_PERIPH_FLAG, 32'h00000002);
		xfer(1'b0, OFF_PERIPH_FLAG, 32'h0);
		`CHK(rd, 32'h00000000)
		// Running timer: control write keeps a freshly written count
		xfer(1'b1, OFF_TIMER_CONTROL, 32'h00000006);
		xfer(1'b1, OFF_TIMER_COUNT, 32'h00000040);
		xfer(1'b1, OFF_TIMER_CONTROL, 32'h00000006);
		xfer(1'b0, OFF_TIMER_COUNT, 32'h0);
		`CHK(rd, 32'h00000040)
		// Stopped timer: count kept over control write, no match even if equal
		xfer(1'b1, OFF_PERIOD_VALUE, 32'h00000005);
		xfer(1'b1, OFF_TIMER_COUNT, 32'h00000005);
		xfer(1'b1, OFF_TIMER_CONTROL, 32'h000000FB);
		xfer(1'b0, OFF_TIMER_COUNT, 32'h0);
		`CHK(rd, 32'h00000005)
		seen = 1'b0;
		repeat (80) begin
			@(posedge pclk);
			seen = seen | match_pulse;
		end
		`CHK(seen, 1'b0)
		xfer(1'b0, OFF_TIMER_CONTROL, 32'h0);
		`CHK(rd, 32'h0000007B)
		xfer(1'b0, OFF_PERIOD_VALUE, 32'h0);
		`CHK(rd, 32'h00000005)
		// Reset in mid-run: count clears, period back to all ones
		xfer(1'b1, OFF_TIMER_CONTROL, 32'h00000004);
		repeat (30) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, OFF_TIMER_COUNT, 32'h0);
		`CHK(rd, 32'h00000000)
		xfer(1'b0, OFF_PERIOD_VALUE, 32'h0);
		`CHK(rd, 32'h000000FF)
		summarize();
	end
endmodule
